/* File: include/mcp_pkg.sv */
// package: register map, field layout, decode and timing constants for modulator clock setup
package mcp_pkg;
    localparam int ADDR_W = 9;
    localparam logic [8:0] OFS_ENABLE = 9'h009;
    localparam logic [8:0] OFS_FACTOR = 9'h00a;
    localparam logic [8:0] OFS_RATE_CONV = 9'h101;
    // field positions
    localparam int FACTOR_LSB = 0;
    localparam int FACTOR_W = 6;
    localparam int BAND_BIT = 6;
    localparam int LOCK_BIT = 7;
    localparam int ENABLE_BIT = 2;
    // reset values: direct clocking, multiplier off
    localparam logic [7:0] RST_ENABLE = 8'h00;
    localparam logic [7:0] RST_FACTOR = 8'h00;
    localparam logic [7:0] RST_RATE_CONV = 8'h00;
    // lock and band search timing
    localparam int CLK_MHZ = 250;
    localparam int LOCK_TIME_NS = 2000;
    localparam int LOCK_CYCLES = (LOCK_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int BAND_COUNT = 8;
    localparam int BAND_W = 3;
    localparam int BAND_DWELL = 4;
    localparam int CNT_W = 16;
    localparam int MULT_W = 6;

    typedef enum logic [3:0] {
        MCP_OFF = 4'b0001,
        MCP_BAND = 4'b0010,
        MCP_ACQ = 4'b0100,
        MCP_LOCKED = 4'b1000
    } mcp_state_e;
endpackage

/* File: rtl/mcp_factor_decode.sv */
// module: factor code to multiplier value table
`timescale 1ns/1ps
module mcp_factor_decode
    import mcp_pkg::*;
(
    input wire logic [mcp_pkg::FACTOR_W-1:0] code,
    output logic [mcp_pkg::MULT_W-1:0] mult
);
    import mcp_pkg::*;

    // ---------------------------------------------
    // decode table
    // ---------------------------------------------
    always_comb begin
        // RULE_11: low code decode
        if (code <= 6'h08) begin
            mult = 6'h08;
        end else if (code == 6'h09) begin
            mult = 6'h09;
        end else if (code <= 6'h0b) begin
            mult = 6'h0a;
        end else if (code <= 6'h0d) begin
            mult = 6'h0c;
        end else if (code <= 6'h11) begin
            mult = code;
        end else if (code <= 6'h13) begin
            mult = 6'h12;
        end else if (code == 6'h14) begin
            mult = 6'h14;
        // RULE_12: high code decode
        end else if (code <= 6'h17) begin
            mult = 6'h15;
        end else if (code == 6'h18) begin
            mult = 6'h18;
        end else if (code <= 6'h1b) begin
            mult = 6'h19;
        end else if (code <= 6'h1d) begin
            mult = 6'h1c;
        end else if (code <= 6'h1f) begin
            mult = 6'h1e;
        end else if (code <= 6'h21) begin
            mult = 6'h20;
        end else if (code <= 6'h29) begin
            mult = 6'h22;
        end else begin
            mult = 6'h2a;
        end
    end
endmodule // mcp_factor_decode

/* File: rtl/mcp_clock_setup.sv */
// module: modulator clock source, multiplier enable, lock and band select control
//
// Notes on behaviour
// RULE_01: after reset the multiplier is bypassed; reference drives modulator path.
// RULE_02: oscillator rate is reference times the decoded factor N.
// RULE_03: modulator clock is oscillator halved, 50% duty.
// RULE_04: reference must be 30 to 160 MHz when multiplier used.
// RULE_05: software writes factor code before setting the enable bit.
// RULE_06: after enable the block acquires lock and reports it in factor bit 7.
// RULE_07: after a factor change software clears and sets enable again.
// RULE_08: bring-up: clock, factor, enable=4, band select, converter 0, converter value.
// RULE_09: band-select bit set makes the block search the best oscillator band.
// RULE_10: after sleep or standby software toggles band-select to rerun search.
// RULE_11: codes 1-8 give 8, up to 20 gives 20.
// RULE_12: codes 21 and above decode up to 42.
// RULE_13: after clock loss software resets and reprograms the rate converter.
// RULE_14: writing zero to the converter field resets the converter.
// RULE_15: software waits for lock before the converter reset step.
`timescale 1ns/1ps
module mcp_clock_setup
    import mcp_pkg::*;
#(
    parameter int LOCK_WAIT = LOCK_CYCLES
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic [mcp_pkg::ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [mcp_pkg::BAND_COUNT-1:0] band_ok,
    output logic mult_in_use,
    output logic [mcp_pkg::MULT_W-1:0] loop_multiply_factor,
    output logic [mcp_pkg::BAND_W-1:0] band_sel,
    output logic pll_locked,
    output logic rate_converter_reset,
    output logic [5:0] rate_converter
);
    import mcp_pkg::*;

    // ---------------------------------------------
    // registers and state
    // ---------------------------------------------
    logic [7:0] enable_reg, next_enable_reg;
    logic [FACTOR_W-1:0] factor_code, next_factor_code;
    logic band_en, next_band_en;
    logic [5:0] conv_field, next_conv_field;
    mcp_state_e state, next_state;
    logic [CNT_W-1:0] cnt, next_cnt;
    logic [BAND_W-1:0] band, next_band;
    logic [BAND_W-1:0] best, next_best;
    logic best_ok, next_best_ok;
    logic [MULT_W-1:0] mult_dec;
    logic [7:0] next_rdata;
    logic [MULT_W-1:0] applied_mult, next_applied_mult;
    logic band_ok_s1;
    logic [BAND_COUNT-1:0] band_ok_s1v, band_ok_s2;
    logic next_conv_reset;

    // RULE_02: factor to multiplier value
    mcp_factor_decode u_decode (
        .code(factor_code),
        .mult(mult_dec)
    );

    // ---------------------------------------------
    // pin synchroniser for band compare flags
    // ---------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            band_ok_s1v <= '0;
            band_ok_s2 <= '0;
        end else if (clk_en) begin
            band_ok_s1v <= band_ok;
            band_ok_s2 <= band_ok_s1v;
        end
    end
    assign band_ok_s1 = band_ok_s2[band];

    // ---------------------------------------------
    // register writes and sequencing
    // ---------------------------------------------
    always_comb begin
        next_enable_reg = enable_reg;
        next_factor_code = factor_code;
        next_band_en = band_en;
        next_conv_field = conv_field;
        next_conv_reset = 1'b0;
        next_state = state;
        next_cnt = cnt;
        next_band = band;
        next_best = best;
        next_best_ok = best_ok;
        next_applied_mult = applied_mult;
        if (reg_wr) begin
            case (reg_addr)
                OFS_ENABLE: begin
                    next_enable_reg = reg_wdata;
                end
                OFS_FACTOR: begin
                    next_factor_code = reg_wdata[FACTOR_LSB +: FACTOR_W];
                    next_band_en = reg_wdata[BAND_BIT];
                end
                OFS_RATE_CONV: begin
                    next_conv_field = reg_wdata[5:0];
                    // RULE_14: zero write resets converter
                    next_conv_reset = (reg_wdata[5:0] == 6'h00);
                end
                default: begin
                end
            endcase
        end
        case (state)
            MCP_OFF: begin
                // RULE_06: enable starts acquisition
                if (enable_reg[ENABLE_BIT]) begin
                    // factor is latched here; later code edits need an enable cycle
                    next_applied_mult = mult_dec;
                    next_cnt = '0;
                    next_band = '0;
                    next_best_ok = 1'b0;
                    next_state = band_en ? MCP_BAND : MCP_ACQ;
                end
            end
            MCP_BAND: begin
                // RULE_09: scan bands, keep first passing one
                next_cnt = cnt + 1'b1;
                if (cnt == CNT_W'(BAND_DWELL - 1)) begin
                    next_cnt = '0;
                    if (band_ok_s1 && !best_ok) begin
                        next_best = band;
                        next_best_ok = 1'b1;
                    end
                    if (band == BAND_W'(BAND_COUNT - 1)) begin
                        next_state = MCP_ACQ;
                    end else begin
                        next_band = band + 1'b1;
                    end
                end
            end
            MCP_ACQ: begin
                next_cnt = cnt + 1'b1;
                if (cnt == CNT_W'(LOCK_WAIT - 1)) begin
                    next_state = MCP_LOCKED;
                end
            end
            MCP_LOCKED: begin
            end
            default: begin
                next_state = MCP_OFF;
            end
        endcase
        // RULE_07: clearing enable drops lock
        if (!enable_reg[ENABLE_BIT]) begin
            next_state = MCP_OFF;
        end
        // RULE_10: band-select rising edge reruns search
        if (next_band_en && !band_en && enable_reg[ENABLE_BIT]) begin
            next_cnt = '0;
            next_band = '0;
            next_best_ok = 1'b0;
            next_state = MCP_BAND;
        end
    end

    always_comb begin
        case (reg_addr)
            OFS_ENABLE: next_rdata = enable_reg;
            // RULE_06: lock status in bit 7
            OFS_FACTOR: next_rdata = {next_state == MCP_LOCKED, band_en, factor_code};
            OFS_RATE_CONV: next_rdata = {2'b00, conv_field};
            default: next_rdata = 8'h00;
        endcase
    end

    // ---------------------------------------------
    // state registers
    // ---------------------------------------------
    always_ff @(posedge ref_clk) begin
        // RULE_01: reset to direct clocking
        if (sys_rst) begin
            enable_reg <= RST_ENABLE;
            factor_code <= RST_FACTOR[FACTOR_W-1:0];
            band_en <= 1'b0;
            conv_field <= RST_RATE_CONV[5:0];
            state <= MCP_OFF;
            cnt <= '0;
            band <= '0;
            best <= '0;
            best_ok <= 1'b0;
            applied_mult <= '0;
            reg_rdata <= 8'h00;
        end else if (clk_en) begin
            enable_reg <= next_enable_reg;
            factor_code <= next_factor_code;
            band_en <= next_band_en;
            conv_field <= next_conv_field;
            state <= next_state;
            cnt <= next_cnt;
            band <= next_band;
            best <= next_best;
            best_ok <= next_best_ok;
            applied_mult <= next_applied_mult;
            reg_rdata <= next_rdata;
        end
    end

    // ---------------------------------------------
    // outputs, all registered
    // ---------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            mult_in_use <= 1'b0;
            loop_multiply_factor <= '0;
            band_sel <= '0;
            pll_locked <= 1'b0;
            rate_converter_reset <= 1'b0;
            rate_converter <= '0;
        end else if (clk_en) begin
            // RULE_03: oscillator halving happens in the clock path once selected
            mult_in_use <= (next_state == MCP_LOCKED);
            loop_multiply_factor <= next_applied_mult;
            band_sel <= (next_state == MCP_BAND) ? next_band : next_best;
            pll_locked <= (next_state == MCP_LOCKED);
            rate_converter_reset <= next_conv_reset;
            rate_converter <= next_conv_field;
        end
    end
endmodule // mcp_clock_setup

/* File: tb/mcp_clock_setup_chk.sv */
// checker: port-level assertions for the modulator clock setup block
`timescale 1ns/1ps
module mcp_clock_setup_chk
    import mcp_pkg::*;
#(
    parameter int LOCK_WAIT = LOCK_CYCLES
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic [mcp_pkg::ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic mult_in_use,
    input wire logic [mcp_pkg::MULT_W-1:0] loop_multiply_factor,
    input wire logic [mcp_pkg::BAND_W-1:0] band_sel,
    input wire logic pll_locked,
    input wire logic rate_converter_reset,
    input wire logic [5:0] rate_converter
);
    import mcp_pkg::*;

    // ----------
    // properties
    // ----------
    // search plus settle, slack for the flag synchroniser
    localparam int MAX_LOCK = BAND_COUNT * BAND_DWELL + LOCK_WAIT + 8;
    wire wr_ok = clk_en & reg_wr;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    a_reset_direct: assert property (disable iff (1'b0) sys_rst |=> !mult_in_use && !pll_locked)
        else $error("outputs not idle after reset");
    a_use_lock: assert property (mult_in_use == pll_locked)
        else $error("multiplier use differs from lock");
    a_lock_bound: assert property (wr_ok && reg_addr == OFS_ENABLE && reg_wdata[ENABLE_BIT]
        && !pll_locked |-> ##[1:MAX_LOCK] pll_locked) else $error("no lock after enable");
    a_unlock_clear: assert property (wr_ok && reg_addr == OFS_ENABLE && !reg_wdata[ENABLE_BIT]
        |-> ##[1:2] !pll_locked) else $error("lock kept after enable cleared");
    a_factor_hold: assert property (pll_locked && $past(pll_locked) |-> $stable(loop_multiply_factor))
        else $error("factor moved while locked");
    a_band_hold: assert property (pll_locked && $past(pll_locked) |-> $stable(band_sel))
        else $error("band moved while locked");
    a_conv_zero: assert property (wr_ok && reg_addr == OFS_RATE_CONV && reg_wdata[5:0] == 6'h00
        |=> rate_converter_reset && rate_converter == 6'h00) else $error("no converter reset");
    a_conv_store: assert property (wr_ok && reg_addr == OFS_RATE_CONV && reg_wdata[5:0] != 6'h00
        |=> !rate_converter_reset && rate_converter == $past(reg_wdata[5:0]))
        else $error("converter value not stored");
    c_lock: cover property ($rose(pll_locked));
    c_conv_reset: cover property (rate_converter_reset);
    c_band: cover property (pll_locked && band_sel != 3'h0);
endmodule // mcp_clock_setup_chk

bind mcp_clock_setup mcp_clock_setup_chk #(.LOCK_WAIT(LOCK_WAIT)) i_chk (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .mult_in_use(mult_in_use), .loop_multiply_factor(loop_multiply_factor),
    .band_sel(band_sel), .pll_locked(pll_locked), .rate_converter_reset(rate_converter_reset),
    .rate_converter(rate_converter));

/* File: tb/mcp_band_src.sv */
// partner model: reference source side presenting per-band usable flags
`timescale 1ns/1ps
module mcp_band_src
    import mcp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic [mcp_pkg::BAND_COUNT-1:0] band_want,
    output logic [mcp_pkg::BAND_COUNT-1:0] band_ok
);
    import mcp_pkg::*;

    // modelled reference rate, value arbitrary inside the legal span
    localparam int REF_MHZ = 100;
    logic [BAND_COUNT-1:0] flags = '0;
    // overlapping usable bands
    // flags move off the edge, as an unrelated source would
    always @(posedge ref_clk) begin
        flags <= #1.3 band_want;
    end
    // no usable band unless reference rate is legal
    assign band_ok = (REF_MHZ >= 30 && REF_MHZ <= 160) ? flags : '0;
endmodule // mcp_band_src

/* File: tb/modulator_clock_pll_setup_tb_top.sv */
// testbench: bring-up, factor table, band search and converter reset
`timescale 1ns/1ps
module modulator_clock_pll_setup_tb_top;
    import mcp_pkg::*;
    typedef struct {int sel; logic [7:0] exp;} mcp_note_s;
    logic ref_clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, reg_wr = 1'b0, probe = 1'b0, probe_d = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [7:0] reg_wdata = '0, reg_rdata, got, v;
    logic [BAND_COUNT-1:0] band_ok, band_want = '0;
    logic mult_in_use, pll_locked, rate_converter_reset;
    logic [MULT_W-1:0] loop_multiply_factor;
    logic [BAND_W-1:0] band_sel;
    logic [5:0] rate_converter;
    mcp_note_s notes[$];
    mcp_note_s n;
    int fails = 0, checks = 0, k, pulses = 0;
    int nv[18] = '{8, 9, 10, 12, 14, 15, 16, 17, 18, 20, 21, 24, 25, 28, 30, 32, 34, 42};
    initial begin
        forever #2 ref_clk = ~ref_clk;
    end
    // short lock wait keeps the run brief
    mcp_clock_setup #(.LOCK_WAIT(4)) i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .band_ok(band_ok), .mult_in_use(mult_in_use), .loop_multiply_factor(loop_multiply_factor),
        .band_sel(band_sel), .pll_locked(pll_locked), .rate_converter_reset(rate_converter_reset),
        .rate_converter(rate_converter));
    mcp_band_src i_src (.ref_clk(ref_clk), .band_want(band_want), .band_ok(band_ok));
    // ---------------------
    // result watcher
    // ---------------------
    always @(posedge ref_clk) begin
        // one-cycle reset pulses are counted so a note can check them later
        if (rate_converter_reset === 1'b1) pulses++;
        probe_d <= probe;
        if (probe_d) begin
            n = notes.pop_front();
            case (n.sel)
                0: got = reg_rdata;
                1: got = {2'b00, loop_multiply_factor};
                2: got = {2'b00, rate_converter};
                4: got = {5'b00000, band_sel};
                5: got = 8'(pulses);
                default: got = {6'h00, pll_locked, mult_in_use};
            endcase
            checks++;
            if (got !== n.exp) begin
                fails++;
                $display("Error at %0t: got %h expected %h", $time, got, n.exp);
            end
        end
    end
    // ---------------------
    // tasks
    // ---------------------
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge ref_clk);
        #1;
        reg_wr = 1'b0;
    endtask
    task automatic note(input int s, input logic [8:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        #1;
        reg_addr = a;
        notes.push_back('{s, e});
        probe = 1'b1;
        @(posedge ref_clk);
        #1;
        probe = 1'b0;
    endtask
    task automatic lock(input logic [7:0] f);
        wr(OFS_FACTOR, f); // factor before enable
        wr(OFS_ENABLE, 8'h04);
        for (k = 0; k < 200 && pll_locked !== 1'b1; k++) @(posedge ref_clk);
        if (pll_locked !== 1'b1) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, pll_locked, 1'b1);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #60000;
        fails++;
        wrap_up();
    end
    // ---------------------
    // tests
    // ---------------------
    initial begin
        void'($urandom(90218));
        repeat (2) @(posedge ref_clk);
        #1;
        sys_rst = 1'b0;
        note(3, OFS_ENABLE, 8'h00);
        note(0, OFS_ENABLE, RST_ENABLE);
        note(0, OFS_FACTOR, RST_FACTOR);
        note(0, OFS_RATE_CONV, RST_RATE_CONV);
        note(0, 9'h0ff, 8'h00);
        $display("test reset done");
        for (int c = 0; c < 64; c++) begin
            v = 8'd8;
            foreach (nv[i]) if (nv[i] <= c) v = 8'(nv[i]);
            lock(8'(c));
            note(1, OFS_FACTOR, v);
            note(0, OFS_FACTOR, 8'h80 | 8'(c));
            note(3, OFS_FACTOR, 8'h03);
            wr(OFS_ENABLE, 8'h00);
            note(3, OFS_ENABLE, 8'h00);
        end
        $display("test factor table done");
        lock(8'd9);
        wr(OFS_FACTOR, 8'd42);
        note(1, OFS_FACTOR, 8'd9);
        wr(OFS_ENABLE, 8'h00); // clear before set
        lock(8'd42);
        note(1, OFS_FACTOR, 8'd42);
        $display("test factor change done");
        repeat (3) begin
            band_want = 8'($urandom_range(1, 255));
            v = 8'h00;
            for (k = 7; k >= 0; k--) if (band_want[k]) v = 8'(k);
            wr(OFS_FACTOR, 8'd25); // band bit low then high
            lock(8'h40 | 8'd25);
            note(4, OFS_FACTOR, v);
        end
        $display("test band search done");
        wr(OFS_RATE_CONV, 8'h00); // reset once locked
        note(2, OFS_RATE_CONV, 8'h00);
        note(5, OFS_RATE_CONV, 8'h01);
        v = 8'($urandom_range(1, 63));
        wr(OFS_RATE_CONV, v);
        note(2, OFS_RATE_CONV, v);
        note(0, OFS_RATE_CONV, v);
        @(posedge ref_clk);
        #1;
        clk_en = 1'b0;
        wr(OFS_RATE_CONV, 8'h00);
        note(2, OFS_RATE_CONV, v);
        clk_en = 1'b1;
        note(5, OFS_RATE_CONV, 8'h01);
        $display("test converter done");
        // the last note compares one edge later, so let it drain first
        repeat (3) @(posedge ref_clk);
        wrap_up();
    end
endmodule // modulator_clock_pll_setup_tb_top
